// File: include/rxcl_pkg.sv
// package: register map, reset values and carriers for the rx clock/link config latches
package rxcl_pkg;
  localparam int unsigned CHANNELS = 4;
  // per-channel config word: one aligned word per channel
  localparam logic [11:0] CFG_BASE   = 12'h0_000;
  localparam logic [11:0] CFG_STRIDE = 12'h0_004;
  // shared status word
  localparam logic [11:0] STAT_ADDR  = 12'h0_010;
  // field positions in a channel config word
  localparam int unsigned SRC_BIT  = 0;
  localparam int unsigned RATE_BIT = 1;
  localparam int unsigned PDL_LSB  = 2;
  localparam int unsigned SDL_LSB  = 4;
  localparam int unsigned ENC_BIT  = 6;
  localparam int unsigned HALF_BIT = 7;
  // values after reset
  localparam logic       SRC_RST  = 1'b1;
  localparam logic       RATE_RST = 1'b1;
  localparam logic [1:0] PDL_RST  = 2'b10;
  localparam logic [1:0] SDL_RST  = 2'b10;
  localparam logic       ENC_RST  = 1'b1;
  localparam logic       HALF_RST = 1'b0;
  // detect level codes
  localparam logic [1:0] DET_OFF  = 2'b00;
  // typical thresholds in mV, per code 01/10/11
  localparam int unsigned THR_LO_MV  = 140;
  localparam int unsigned THR_MID_MV = 280;
  localparam int unsigned THR_HI_MV  = 420;

  typedef struct packed {
    logic       half_ref;  // reference is a half-rate clock
    logic       enc_en;
    logic [1:0] sec_lvl;
    logic [1:0] pri_lvl;
    logic       rate;      // 1 = half character rate
    logic       src;       // 1 = reference clock
  } rxcl_cfg_s;

  typedef struct packed {
    logic       pri_det_en;
    logic [1:0] pri_thr;   // 0 lo, 1 mid, 2 hi
    logic       sec_det_en;
    logic [1:0] sec_thr;
  } rxcl_det_s;
endpackage

// File: verilog/rxcl_top.sv
// rx clock source/rate, detect level and encoder enable latches for four channels
//
// How it works
// RULE_01 - source select resets to reference clock
// RULE_02 - source 1: reference clocks outputs and pair
// RULE_03 - source 0: recovered byte clock drives outputs
// RULE_04 - rate select resets to half rate
// RULE_05 - recovered, rate 1: complementary half-rate clocks
// RULE_06 - recovered, rate 0: complementary full-rate clocks
// RULE_07 - reference full, rate 1: half-rate clocks
// RULE_08 - reference full, rate 0: character-rate clocks
// RULE_09 - half-rate reference ignores rate select
// RULE_10 - primary detect level resets to 10
// RULE_11 - primary level 00 disables detector
// RULE_12 - primary codes 01..11 raise threshold
// RULE_13 - secondary detect level resets to 10
// RULE_14 - secondary 00 off, same thresholds
// RULE_15 - encoder enable resets to one
// RULE_16 - encoder 0 bypasses, raw characters sent
// RULE_17 - each channel keeps its own latches
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/10ps
module rxcl_top
  import rxcl_pkg::*;
#(
  parameter int unsigned NCH = CHANNELS
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // link side, per channel
  input  wire logic [NCH-1:0]   channel_reference_clock,
  input  wire logic [NCH-1:0]   recovered_byte_clock,
  input  wire logic [NCH-1:0]   rx_link_rst_n,
  output logic      [NCH-1:0]   rx_output_clock_pair_p,
  output logic      [NCH-1:0]   rx_output_clock_pair_n,
  output logic      [NCH-1:0]   rx_clock_is_half_rate,
  output rxcl_det_s [NCH-1:0]   detect_ctrl,
  output logic      [NCH-1:0]   tx_encoder_enable_latch
);

  rxcl_cfg_s [NCH-1:0] cfg_q;
  logic      [NCH-1:0] hit;
  logic                stat_hit;
  logic                apb_wr;
  logic                apb_rd;
  logic      [NCH-1:0] clk_run;   // link-side running indication, per channel

  // apb: zero-wait, one access cycle
  assign pready  = 1'b1;
  assign apb_wr  = psel & penable & pwrite;
  assign apb_rd  = psel & penable & ~pwrite;
  assign stat_hit = (paddr == STAT_ADDR);

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic [2:0] sync_q;    // link toggle into mclk, three stages
      logic       seen_q;
      logic       tog_q;     // runs on the selected clock
      logic       div_q;
      logic       sel_clk;
      logic       eff_half;

      // address decode for this channel's word
      assign hit[g] = (paddr == 12'(CFG_BASE + CFG_STRIDE * g));

      // separate latch set per channel [RULE_17]
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_q[g].src      <= SRC_RST;   // [RULE_01]
          cfg_q[g].rate     <= RATE_RST;  // [RULE_04]
          cfg_q[g].pri_lvl  <= PDL_RST;   // [RULE_10]
          cfg_q[g].sec_lvl  <= SDL_RST;   // [RULE_13]
          cfg_q[g].enc_en   <= ENC_RST;   // [RULE_15]
          cfg_q[g].half_ref <= HALF_RST;
        end else if (apb_wr && hit[g]) begin
          cfg_q[g].src      <= pwdata[SRC_BIT];
          cfg_q[g].rate     <= pwdata[RATE_BIT];
          cfg_q[g].pri_lvl  <= pwdata[PDL_LSB+:2];
          cfg_q[g].sec_lvl  <= pwdata[SDL_LSB+:2];
          cfg_q[g].enc_en   <= pwdata[ENC_BIT];
          cfg_q[g].half_ref <= pwdata[HALF_BIT];
        end
      end

      // output register clock: reference when src=1, recovered when 0
      assign sel_clk = cfg_q[g].src ? channel_reference_clock[g]    // [RULE_02]
                                    : recovered_byte_clock[g];      // [RULE_03]

      // half-rate reference is passed undivided and flagged half rate, rate select ignored [RULE_09]
      assign eff_half = (cfg_q[g].src && cfg_q[g].half_ref) ? 1'b0 : cfg_q[g].rate;

      // divide by two in the selected clock's domain; config is quasi-static
      always_ff @(posedge sel_clk or negedge rx_link_rst_n[g]) begin
        if (!rx_link_rst_n[g]) begin
          div_q <= 1'b0;
          tog_q <= 1'b0;
        end else begin
          div_q <= ~div_q;
          tog_q <= ~tog_q;
        end
      end

      // complementary pair: half rate divides, full rate follows [RULE_05] [RULE_07]
      // full rate passes the selected clock itself [RULE_06] [RULE_08]
      assign rx_output_clock_pair_p[g] = eff_half ? div_q : sel_clk;
      assign rx_output_clock_pair_n[g] = ~rx_output_clock_pair_p[g];
      assign rx_clock_is_half_rate[g]  = eff_half | (cfg_q[g].src & cfg_q[g].half_ref);

      // detector controls: 00 disables, codes map to rising thresholds
      assign detect_ctrl[g].pri_det_en = (cfg_q[g].pri_lvl != DET_OFF);          // [RULE_11]
      assign detect_ctrl[g].pri_thr    = cfg_q[g].pri_lvl - 2'd1;               // [RULE_12]
      assign detect_ctrl[g].sec_det_en = (cfg_q[g].sec_lvl != DET_OFF);          // [RULE_14]
      assign detect_ctrl[g].sec_thr    = cfg_q[g].sec_lvl - 2'd1;               // [RULE_14]

      // encoder enable: 1 encodes, 0 bypasses raw 10-bit characters [RULE_16]
      assign tx_encoder_enable_latch[g] = cfg_q[g].enc_en;

      // selected clock activity toggle crosses into mclk
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          sync_q <= 3'b000;
          seen_q <= 1'b0;
        end else begin
          sync_q <= {sync_q[1:0], tog_q};
          seen_q <= sync_q[2] ^ sync_q[1];
        end
      end
      assign clk_run[g] = seen_q;

      // a channel's latches reset to their documented values
      property p_rst_values;
        @(posedge mclk) $rose(rst_n) |->
          cfg_q[g].src && cfg_q[g].rate && cfg_q[g].pri_lvl == 2'b10 &&
          cfg_q[g].sec_lvl == 2'b10 && cfg_q[g].enc_en;
      endproperty
      a_rst_values: assert property (p_rst_values) // [RULE_01]
        else $error("latch reset values wrong");

      property p_write_lands;
        @(posedge mclk) disable iff (!rst_n)
          apb_wr && hit[g] |=> cfg_q[g].src == $past(pwdata[SRC_BIT]) &&
                               cfg_q[g].enc_en == $past(pwdata[ENC_BIT]);
      endproperty
      a_write_lands: assert property (p_write_lands) // [RULE_17]
        else $error("channel write not stored");

      property p_other_hold;
        @(posedge mclk) disable iff (!rst_n)
          !(apb_wr && hit[g]) |=> $stable(cfg_q[g]);
      endproperty
      a_other_hold: assert property (p_other_hold) // [RULE_17]
        else $error("channel latch changed without its write");

      property p_pri_off;
        @(posedge mclk) disable iff (!rst_n)
          detect_ctrl[g].pri_det_en == (cfg_q[g].pri_lvl != 2'b00);
      endproperty
      a_pri_off: assert property (p_pri_off) // [RULE_11]
        else $error("primary detector enable wrong");

      property p_sec_thr;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].sec_lvl == 2'b11 |-> detect_ctrl[g].sec_thr == 2'd2;
      endproperty
      a_sec_thr: assert property (p_sec_thr) // [RULE_14]
        else $error("secondary threshold code wrong");

      property p_pri_thr;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].pri_lvl == 2'b01 |-> detect_ctrl[g].pri_thr == 2'd0;
      endproperty
      a_pri_thr: assert property (p_pri_thr) // [RULE_12]
        else $error("primary threshold code wrong");

      property p_half_ignore;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].src && cfg_q[g].half_ref |-> rx_clock_is_half_rate[g];
      endproperty
      a_half_ignore: assert property (p_half_ignore) // [RULE_09]
        else $error("half-rate reference not honoured");

      property p_enc;
        @(posedge mclk) disable iff (!rst_n)
          apb_wr && hit[g] |=> tx_encoder_enable_latch[g] == $past(pwdata[ENC_BIT]);
      endproperty
      a_enc: assert property (p_enc) // [RULE_16]
        else $error("encoder enable not following latch");

      property p_rate;
        @(posedge mclk) disable iff (!rst_n)
          !cfg_q[g].half_ref |-> rx_clock_is_half_rate[g] == cfg_q[g].rate;
      endproperty
      a_rate: assert property (p_rate) // [RULE_05]
        else $error("rate indication wrong");

      // clock source selection and output pair shape
      property p_sel_ref;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].src |-> sel_clk == channel_reference_clock[g];
      endproperty
      a_sel_ref: assert property (p_sel_ref) // [RULE_02]
        else $error("reference clock not selected");

      property p_sel_rec;
        @(posedge mclk) disable iff (!rst_n)
          !cfg_q[g].src |-> sel_clk == recovered_byte_clock[g];
      endproperty
      a_sel_rec: assert property (p_sel_rec) // [RULE_03]
        else $error("recovered clock not selected");

      property p_pair_comp;
        @(posedge mclk) disable iff (!rst_n)
          rx_output_clock_pair_n[g] == ~rx_output_clock_pair_p[g];
      endproperty
      a_pair_comp: assert property (p_pair_comp) // [RULE_05]
        else $error("output pair not complementary");

      property p_full_follow;
        @(posedge mclk) disable iff (!rst_n)
          !eff_half |-> rx_output_clock_pair_p[g] == sel_clk;
      endproperty
      a_full_follow: assert property (p_full_follow) // [RULE_06]
        else $error("full rate pair not following clock");

      property p_half_div;
        @(posedge mclk) disable iff (!rst_n)
          eff_half |-> rx_output_clock_pair_p[g] == div_q;
      endproperty
      a_half_div: assert property (p_half_div) // [RULE_07]
        else $error("half rate pair not divided");

      property p_ref_rate;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].src && !cfg_q[g].half_ref |-> rx_clock_is_half_rate[g] == cfg_q[g].rate;
      endproperty
      a_ref_rate: assert property (p_ref_rate) // [RULE_08]
        else $error("reference rate indication wrong");

      property p_rec_rate;
        @(posedge mclk) disable iff (!rst_n)
          !cfg_q[g].src |-> rx_clock_is_half_rate[g] == cfg_q[g].rate;
      endproperty
      a_rec_rate: assert property (p_rec_rate) // [RULE_06]
        else $error("recovered rate indication wrong");

      // detector codes
      property p_sec_off;
        @(posedge mclk) disable iff (!rst_n)
          detect_ctrl[g].sec_det_en == (cfg_q[g].sec_lvl != 2'h0);
      endproperty
      a_sec_off: assert property (p_sec_off) // [RULE_14]
        else $error("secondary detector enable wrong");

      property p_pri_mid;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].pri_lvl == 2'h2 |-> detect_ctrl[g].pri_thr == 2'h1;
      endproperty
      a_pri_mid: assert property (p_pri_mid) // [RULE_12]
        else $error("primary middle threshold wrong");

      property p_pri_hi;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].pri_lvl == 2'h3 |-> detect_ctrl[g].pri_thr == 2'h2;
      endproperty
      a_pri_hi: assert property (p_pri_hi) // [RULE_12]
        else $error("primary high threshold wrong");

      property p_sec_lo;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].sec_lvl == 2'h1 |-> detect_ctrl[g].sec_thr == 2'h0;
      endproperty
      a_sec_lo: assert property (p_sec_lo) // [RULE_14]
        else $error("secondary low threshold wrong");

      property p_sec_mid;
        @(posedge mclk) disable iff (!rst_n)
          cfg_q[g].sec_lvl == 2'h2 |-> detect_ctrl[g].sec_thr == 2'h1;
      endproperty
      a_sec_mid: assert property (p_sec_mid) // [RULE_14]
        else $error("secondary middle threshold wrong");

      // writes land in the rate and level fields, encoder holds without a write, reset values show on the outputs
      property p_rate_write;
        @(posedge mclk) disable iff (!rst_n)
          apb_wr && hit[g] |=> cfg_q[g].rate == $past(pwdata[RATE_BIT]);
      endproperty
      a_rate_write: assert property (p_rate_write) // [RULE_04]
        else $error("rate select write not stored");

      property p_lvl_write;
        @(posedge mclk) disable iff (!rst_n)
          apb_wr && hit[g] |=> cfg_q[g].pri_lvl == $past(pwdata[PDL_LSB+:2]) &&
                               cfg_q[g].sec_lvl == $past(pwdata[SDL_LSB+:2]);
      endproperty
      a_lvl_write: assert property (p_lvl_write) // [RULE_10]
        else $error("detect level write not stored");

      property p_enc_hold;
        @(posedge mclk) disable iff (!rst_n)
          !(apb_wr && hit[g]) |=> $stable(tx_encoder_enable_latch[g]);
      endproperty
      a_enc_hold: assert property (p_enc_hold) // [RULE_16]
        else $error("encoder enable changed without write");

      property p_rst_enc;
        @(posedge mclk) $rose(rst_n) |-> tx_encoder_enable_latch[g];
      endproperty
      a_rst_enc: assert property (p_rst_enc) // [RULE_15]
        else $error("encoder enable not set after reset");

      property p_rst_det;
        @(posedge mclk) $rose(rst_n) |->
          detect_ctrl[g].pri_det_en && detect_ctrl[g].pri_thr == 2'h1 &&
          detect_ctrl[g].sec_det_en && detect_ctrl[g].sec_thr == 2'h1;
      endproperty
      a_rst_det: assert property (p_rst_det) // [RULE_13]
        else $error("detector controls wrong after reset");
    end
  endgenerate

  // read data register and error answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= 32'h0000_0000;
      for (int i = 0; i < NCH; i++) begin
        if (hit[i]) begin
          prdata <= {24'h00_0000, cfg_q[i]};
        end
      end
      if (stat_hit) begin
        prdata <= {{(32-NCH){1'b0}}, clk_run};
      end
    end
  end

  // unmapped address answers with an error
  assign pslverr = psel & penable & ~(|hit | (stat_hit & ~pwrite));

  // bus answer checks
  property p_pready;
    @(posedge mclk) disable iff (!rst_n)
      pready;
  endproperty
  a_pready: assert property (p_pready) // [RULE_17]
    else $error("ready not high");

  property p_unmapped;
    @(posedge mclk) disable iff (!rst_n)
      psel && penable && !(|hit) && !stat_hit |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) // [RULE_17]
    else $error("unmapped access without error");

  property p_mapped_ok;
    @(posedge mclk) disable iff (!rst_n)
      psel && penable && (|hit) |-> !pslverr;
  endproperty
  a_mapped_ok: assert property (p_mapped_ok) // [RULE_17]
    else $error("channel access answered with error");

  property p_read_ch0;
    @(posedge mclk) disable iff (!rst_n)
      psel && !penable && !pwrite && hit[0] |=> prdata == {24'h00_0000, $past(cfg_q[0])};
  endproperty
  a_read_ch0: assert property (p_read_ch0) // [RULE_17]
    else $error("channel read data wrong");

  property p_upper_zero;
    @(posedge mclk) disable iff (!rst_n)
      prdata[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // [RULE_17]
    else $error("unused read bits not zero");

endmodule

// File: sim/rxcl_host_model.sv
// host model: makes the recovered clocks, counts output clock captures per channel
`timescale 1ns/10ps
module rxcl_host_model (
  input  wire logic       link_clk,
  input  wire logic       clr,
  input  wire logic [3:0] out_p,
  input  wire logic [3:0] out_n,
  output logic      [3:0] rec_clk,
  output int              edges [4],
  output int              skew_errs
);
  // recovered byte clock runs at half the reference rate, so sources differ
  initial rec_clk = 4'h0;
  always @(posedge link_clk) rec_clk <= ~rec_clk;
  // pair must stay complementary while capturing (sampled on falling link clock edges)
  initial skew_errs = 0;
  always @(negedge link_clk) if (!clr && out_p !== ~out_n) skew_errs <= skew_errs + 1;
  for (genvar i = 0; i < 4; i++) begin : g_ch
    // capture on each true rising edge (complement falling edge is the same instant)
    always @(posedge out_p[i] or posedge clr) begin
      if (clr) edges[i] <= 0;
      else edges[i] <= edges[i] + 1;
    end
  end
endmodule

// File: sim/tb.sv
// testbench: apb access to the latches, detect codes, encoder and output clock rates
`timescale 1ns/10ps
module tb;
  import rxcl_pkg::*;
  logic            mclk, rst_n, link_clk, psel, penable, pwrite, clr, pready, pslverr, er;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [3:0]      rec_clk, lrst_n, out_p, out_n, half, enc;
  rxcl_det_s [3:0] det;
  int              edges [4];
  int              skew_errs, failures, check_count;
  rxcl_top uut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_reference_clock({4{link_clk}}), .recovered_byte_clock(rec_clk),
    .rx_link_rst_n(lrst_n), .rx_output_clock_pair_p(out_p), .rx_output_clock_pair_n(out_n),
    .rx_clock_is_half_rate(half), .detect_ctrl(det), .tx_encoder_enable_latch(enc));
  rxcl_host_model host (.link_clk(link_clk), .clr(clr), .out_p(out_p), .out_n(out_n),
    .rec_clk(rec_clk), .edges(edges), .skew_errs(skew_errs));
  // clocks: 50 ns register clock, 30 ns link clock at an odd phase
  initial begin mclk = 0; forever #25 mclk = ~mclk; end
  initial begin link_clk = 0; #7; forever #15 link_clk = ~link_clk; end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one apb transfer; waits for pready under a bound, then idles one cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge mclk);
    penable <= 1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin failures++; end_of_test(); end
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge mclk);
  endtask
  function automatic logic [31:0] cfgw(logic s, logic r, logic [1:0] p, logic [1:0] q,
                                       logic e, logic h);
    return 32'(s) << SRC_BIT | 32'(r) << RATE_BIT | 32'(p) << PDL_LSB | 32'(q) << SDL_LSB
         | 32'(e) << ENC_BIT | 32'(h) << HALF_BIT;
  endfunction
  task automatic t_reset();
    for (int c = 0; c < 4; c++) begin
      apb(0, 12'(4 * c), 0);
      chk("reset word", rd, 32'h0000_006B);
    end
    chk("reset outs", {det[3], enc, half}, {6'h2D, 4'hF, 4'hF});
    $display("test reset done");
  endtask
  task automatic t_detect();
    for (int k = 0; k < 4; k++) begin
      apb(1, 12'h008, cfgw(1, 1, 2'(k), 2'(3 - k), 1, 0));
      chk("det ch2", det[2], {k != 0, 2'(k - 1), k != 3, 2'(2 - k)});
      chk("det ch1", det[1], 6'h2D);
    end
    $display("test detect done");
  endtask
  task automatic t_encoder();
    apb(1, 12'h00C, cfgw(1, 1, 2'b10, 2'b10, 0, 0));
    chk("enc", enc, 4'h7);
    apb(0, 12'h00C, 0);
    chk("enc word", rd, 32'h0000_002B);
    $display("test encoder done");
  endtask
  task automatic t_clocks();
    logic [2:0] m [5] = '{3'b100, 3'b110, 3'b000, 3'b010, 3'b101}; // source, rate, half ref
    int ex [5] = '{100, 50, 50, 25, 100};
    for (int k = 0; k < 5; k++) begin
      apb(1, 12'h000, cfgw(m[k][2], m[k][1], 2'b10, 2'b10, 1, m[k][0]));
      chk("half flag", half[0], m[k][1] | (m[k][2] & m[k][0]));
      clr <= 0;
      repeat (60) @(posedge mclk);
      chk("edges", 32'(edges[0] >= ex[k] - 2 && edges[0] <= ex[k] + 2), 1);
      chk("ch1 edges", 32'(edges[1] >= 48 && edges[1] <= 52), 1);
      clr <= 1;
      @(posedge mclk);
    end
    chk("pair skew", skew_errs, 0);
    $display("test clocks done");
  endtask
  task automatic t_refuse();
    apb(0, 12'h014, 0);
    chk("unmapped err", er, 1);
    apb(1, STAT_ADDR, 32'h0000_00FF);
    chk("status wr err", er, 1);
    apb(0, 12'h004, 0);
    chk("ch1 kept", rd, 32'h0000_006B);
    $display("test refuse done");
  endtask
  initial begin
    rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; lrst_n = 0; clr = 1;
    failures = 0; check_count = 0;
    repeat (5) @(posedge mclk);
    rst_n <= 1;
    lrst_n <= 4'hF;
    @(posedge mclk);
    t_reset();
    t_detect();
    t_encoder();
    t_clocks();
    t_refuse();
    end_of_test();
  end
endmodule
